// ===== core/twr_pkg.sv
package twr_pkg;

  // ==========================================================================
  // register indices on the plain register port
  localparam logic [1:0] REG_OWN_ADDR = 2'h0;
  localparam logic [1:0] REG_CONTROL  = 2'h1;
  localparam logic [1:0] REG_STATUS   = 2'h2;
  localparam logic [1:0] REG_DATA     = 2'h3;

  // ==========================================================================
  // field positions
  localparam int CTL_DONE     = 7;
  localparam int CTL_ACK      = 6;
  localparam int CTL_STA      = 5;
  localparam int CTL_STO      = 4;
  localparam int CTL_WCOL     = 3;
  localparam int CTL_EN       = 2;
  localparam int CTL_IE       = 0;
  localparam int OWN_GCE_BIT  = 0;
  localparam int PRESC_LSB    = 0;
  localparam int PRESC_W      = 2;

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0] OWN_RESET        = 8'hFE;
  localparam logic [7:0] STATUS_CODE_MASK = 8'hF8;

  // ==========================================================================
  // bus constants
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic       DIR_WRITE         = 1'b0;
  localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

  // ==========================================================================
  // status codes, low three bits always zero
  localparam logic [7:0] CODE_OWN_ADDR     = 8'h60;
  localparam logic [7:0] CODE_ARB_OWN_ADDR = 8'h68;
  localparam logic [7:0] CODE_GC_ADDR      = 8'h70;
  localparam logic [7:0] CODE_ARB_GC_ADDR  = 8'h78;
  localparam logic [7:0] CODE_DATA_ACK     = 8'h80;
  localparam logic [7:0] CODE_DATA_NACK    = 8'h88;
  localparam logic [7:0] CODE_GC_DATA_ACK  = 8'h90;
  localparam logic [7:0] CODE_GC_DATA_NACK = 8'h98;
  localparam logic [7:0] CODE_STOP_RESTART = 8'hA0;
  localparam logic [7:0] CODE_NONE         = 8'hF8;

  // ==========================================================================
  // receiver states
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WAIT,
    S_DATA,
    S_DATA_ACK,
    S_XMIT,
    S_IGNORE
  } twr_state_t;

endpackage

// ===== core/twr_mon_if.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// synchronised line events from the monitor to the receiver
interface twr_mon_if;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport mon  (output sda, scl_rise, scl_fall, start, stop);
  modport core (input  sda, scl_rise, scl_fall, start, stop);
endinterface

`default_nettype wire

// ===== core/twr_bus_mon.sv
`timescale 1ns/1ps
`default_nettype none

module twr_bus_mon
(
  // clock, reset and enable
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  input  wire logic  ce_i,
  // raw bus lines
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  // events
  twr_mon_if.mon     mon
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
  } twr_mon_regs_t;

  // idle bus reads high, so reset to high avoids a false edge
  localparam twr_mon_regs_t MON_RESET = '1;

  twr_mon_regs_t m_reg;
  twr_mon_regs_t m_next;

  always_comb
  begin
    m_next        = m_reg;
    m_next.scl_s1 = scl_i;
    m_next.sda_s1 = sda_i;
    m_next.scl_s2 = m_reg.scl_s1;
    m_next.sda_s2 = m_reg.sda_s1;
    m_next.scl_d  = m_reg.scl_s2;
    m_next.sda_d  = m_reg.sda_s2;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      m_reg <= MON_RESET;
    else if (ce_i)
      m_reg <= m_next;
  end

  // ==========================================================================
  // events, from second stage onward only
  assign mon.sda      = m_reg.sda_s2;
  assign mon.scl_rise = m_reg.scl_s2 & ~m_reg.scl_d;
  assign mon.scl_fall = ~m_reg.scl_s2 & m_reg.scl_d;
  assign mon.start    = m_reg.scl_s2 & m_reg.scl_d & m_reg.sda_d
                        & ~m_reg.sda_s2;
  assign mon.stop     = m_reg.scl_s2 & m_reg.scl_d & ~m_reg.sda_d
                        & m_reg.sda_s2;

endmodule

`default_nettype wire

// ===== core/twr_slave_rx.sv
`timescale 1ns/1ps
`default_nettype none

module twr_slave_rx
#(
  parameter int REG_AW = 2
)
(
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  // register port
  input  wire logic [REG_AW-1:0] addr_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rd_data_o,
  // two-wire bus lines
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  // system side
  input  wire logic              sleep_i,
  input  wire logic              arb_lost_i,
  output logic                   wake_o,
  output logic                   start_go_o,
  output logic                   slave_tx_o
);

  if (REG_AW < 2)
  begin : g_bad_aw
    $error("REG_AW must be at least 2");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    twr_pkg::twr_state_t st;
    logic [7:0]          own_addr;
    logic                ack_en;
    logic                sta_req;
    logic                sto_req;
    logic                wcol;
    logic                if_en;
    logic                irq_en;
    logic                flag;
    logic [1:0]          presc;
    logic [7:0]          code;
    logic [7:0]          data;
    logic [7:0]          shift;
    logic [3:0]          bitcnt;
    logic                gc;
    logic                ack_given;
    logic                drop;
    logic                arb;
    logic                busy;
    logic                sda_oe;
    logic                scl_oe;
    logic                wake;
    logic                start_go;
    logic                slave_tx;
    logic [7:0]          rd_data;
    logic                line_low;
  } twr_regs_t;

  localparam twr_regs_t REGS_RESET = '{
    st:       twr_pkg::S_IDLE,
    own_addr: twr_pkg::OWN_RESET,
    code:     twr_pkg::CODE_NONE,
    default:  '0
  };

  twr_regs_t s_reg;
  twr_regs_t s_next;

  twr_mon_if mon ();

  twr_bus_mon u_mon
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .mon       (mon.mon)
  );

  // ==========================================================================
  // decode helpers
  logic hi_ok;
  logic own_hit;
  logic gc_hit;
  logic may_ack;
  logic flag_clr;
  logic byte_end;

  assign hi_ok    = (addr_i >> 2) == '0;
  assign own_hit  = s_reg.shift[7:1] == s_reg.own_addr[7:1];
  // general call gated by bit zero
  assign gc_hit   = (s_reg.shift[7:1] == twr_pkg::GENERAL_CALL_ADDR)
                    && s_reg.own_addr[twr_pkg::OWN_GCE_BIT];
  assign may_ack  = s_reg.if_en && s_reg.ack_en;
  assign flag_clr = wr_i && hi_ok && (addr_i[1:0] == twr_pkg::REG_CONTROL)
                    && wr_data_i[twr_pkg::CTL_DONE];
  assign byte_end = mon.scl_fall && (s_reg.bitcnt == twr_pkg::BITS_PER_BYTE);

  // ==========================================================================
  // next state
  always_comb
  begin
    s_next = s_reg;

    // register writes; bus events below override, so a set wins a clear
    if (wr_i && hi_ok)
    begin
      if (addr_i[1:0] == twr_pkg::REG_OWN_ADDR)
        s_next.own_addr = wr_data_i;
      else if (addr_i[1:0] == twr_pkg::REG_CONTROL)
      begin
        s_next.ack_en  = wr_data_i[twr_pkg::CTL_ACK];
        s_next.sta_req = wr_data_i[twr_pkg::CTL_STA];
        s_next.sto_req = wr_data_i[twr_pkg::CTL_STO];
        s_next.if_en   = wr_data_i[twr_pkg::CTL_EN];
        s_next.irq_en  = wr_data_i[twr_pkg::CTL_IE];
        if (wr_data_i[twr_pkg::CTL_DONE])
          s_next.flag = 1'b0;
      end
      else if (addr_i[1:0] == twr_pkg::REG_STATUS)
        s_next.presc = wr_data_i[twr_pkg::PRESC_LSB +: twr_pkg::PRESC_W];
      else if (s_reg.flag)
      begin
        s_next.data = wr_data_i;
        s_next.wcol = 1'b0;
      end
      else
        s_next.wcol = 1'b1;
    end

    // register reads, answered one cycle later
    if (rd_i)
    begin
      if (!hi_ok)
        s_next.rd_data = 8'h00;
      else if (addr_i[1:0] == twr_pkg::REG_OWN_ADDR)
        s_next.rd_data = s_reg.own_addr;
      else if (addr_i[1:0] == twr_pkg::REG_CONTROL)
        s_next.rd_data = {s_reg.flag, s_reg.ack_en, s_reg.sta_req,
                          s_reg.sto_req, s_reg.wcol, s_reg.if_en, 1'b0,
                          s_reg.irq_en};
      else if (addr_i[1:0] == twr_pkg::REG_STATUS)
        s_next.rd_data = (s_reg.code & twr_pkg::STATUS_CODE_MASK)
                         | {6'h00, s_reg.presc};
      else
        s_next.rd_data = s_reg.data;
    end

    if (mon.start)
      s_next.busy = 1'b1;
    else if (mon.stop)
      s_next.busy = 1'b0;
    if (arb_lost_i)
      s_next.arb = 1'b1;

    s_next.start_go = (s_reg.st == twr_pkg::S_IDLE) && s_reg.sta_req
                      && !s_reg.busy && s_reg.if_en;

    case (s_reg.st)
      twr_pkg::S_IDLE:
      begin
        s_next.sda_oe   = 1'b0;
        s_next.scl_oe   = 1'b0;
        s_next.slave_tx = 1'b0;
        if (mon.start)
        begin
          s_next.st     = twr_pkg::S_ADDR;
          s_next.bitcnt = 4'h0;
        end
      end
      twr_pkg::S_ADDR:
      begin
        if (mon.stop)
          s_next.st = twr_pkg::S_IDLE;
        else if (mon.start)
          s_next.bitcnt = 4'h0;
        else if (mon.scl_rise)
        begin
          s_next.shift  = {s_reg.shift[6:0], mon.sda};
          s_next.bitcnt = s_reg.bitcnt + 4'h1;
        end
        else if (byte_end)
        begin
          if (may_ack && (own_hit || gc_hit))
          begin
            s_next.sda_oe = 1'b1;
            s_next.gc     = gc_hit && !own_hit;
            if (s_reg.shift[0] == twr_pkg::DIR_WRITE)
              s_next.st = twr_pkg::S_ADDR_ACK;
            else
            begin
              s_next.st       = twr_pkg::S_XMIT;
              s_next.slave_tx = 1'b1;
            end
          end
          else
            s_next.st = twr_pkg::S_IGNORE;
        end
      end
      twr_pkg::S_ADDR_ACK:
      begin
        if (mon.scl_fall)
        begin
          s_next.sda_oe = 1'b0;
          s_next.scl_oe = 1'b1;
          s_next.flag   = 1'b1;
          s_next.drop   = 1'b0;
          s_next.arb    = 1'b0;
          s_next.st     = twr_pkg::S_WAIT;
          if (s_reg.gc)
            s_next.code = s_reg.arb ? twr_pkg::CODE_ARB_GC_ADDR
                                    : twr_pkg::CODE_GC_ADDR;
          else
            s_next.code = s_reg.arb ? twr_pkg::CODE_ARB_OWN_ADDR
                                    : twr_pkg::CODE_OWN_ADDR;
          if (sleep_i)
            s_next.wake = 1'b1;
        end
      end
      twr_pkg::S_WAIT:
      begin
        if (!s_reg.flag)
        begin
          s_next.scl_oe = 1'b0;
          s_next.wake   = 1'b0;
          s_next.bitcnt = 4'h0;
          s_next.st     = s_reg.drop ? twr_pkg::S_IDLE : twr_pkg::S_DATA;
        end
      end
      twr_pkg::S_DATA:
      begin
        if (mon.stop || mon.start)
        begin
          s_next.flag   = 1'b1;
          s_next.code   = twr_pkg::CODE_STOP_RESTART;
          s_next.bitcnt = 4'h0;
          s_next.st     = mon.start ? twr_pkg::S_ADDR : twr_pkg::S_IDLE;
        end
        else if (mon.scl_rise)
        begin
          s_next.shift  = {s_reg.shift[6:0], mon.sda};
          s_next.bitcnt = s_reg.bitcnt + 4'h1;
        end
        else if (byte_end)
        begin
          s_next.ack_given = s_reg.ack_en;
          s_next.sda_oe    = s_reg.ack_en;
          s_next.st        = twr_pkg::S_DATA_ACK;
        end
      end
      twr_pkg::S_DATA_ACK:
      begin
        if (mon.scl_fall)
        begin
          // of the bus phases, only data phases load the data byte
          s_next.data   = s_reg.shift;
          s_next.sda_oe = 1'b0;
          s_next.scl_oe = 1'b1;
          s_next.flag   = 1'b1;
          s_next.drop   = !s_reg.ack_given;
          s_next.st     = twr_pkg::S_WAIT;
          if (s_reg.gc)
            s_next.code = s_reg.ack_given ? twr_pkg::CODE_GC_DATA_ACK
                                          : twr_pkg::CODE_GC_DATA_NACK;
          else
            s_next.code = s_reg.ack_given ? twr_pkg::CODE_DATA_ACK
                                          : twr_pkg::CODE_DATA_NACK;
        end
      end
      default:
      begin
        // transmit side is parked; the address ack bit is held to its end
        if (mon.scl_fall || mon.stop || mon.start)
          s_next.sda_oe = 1'b0;
        if (mon.stop)
          s_next.st = twr_pkg::S_IDLE;
        else if (mon.start)
        begin
          s_next.slave_tx = 1'b0;
          s_next.bitcnt   = 4'h0;
          s_next.st       = twr_pkg::S_ADDR;
        end
      end
    endcase

    // disabled interface lets go of both lines at once
    if (!s_reg.if_en)
    begin
      s_next.st       = twr_pkg::S_IDLE;
      s_next.sda_oe   = 1'b0;
      s_next.scl_oe   = 1'b0;
      s_next.slave_tx = 1'b0;
      s_next.wake     = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_reg <= REGS_RESET;
    else if (ce_i)
      s_reg <= s_next;
  end

  // ==========================================================================
  // outputs
  assign rd_data_o  = s_reg.rd_data;
  assign scl_o      = s_reg.line_low;
  assign scl_oe_o   = s_reg.scl_oe;
  assign sda_o      = s_reg.line_low;
  assign sda_oe_o   = s_reg.sda_oe;
  assign wake_o     = s_reg.wake;
  assign start_go_o = s_reg.start_go;
  assign slave_tx_o = s_reg.slave_tx;

  // ==========================================================================
  // checks
  a_stretch_hold:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (s_reg.st == twr_pkg::S_WAIT && s_reg.flag) |-> scl_oe_o)
  else $error("clock not held while flag set");

  a_wake_hold:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wake_o |-> (scl_oe_o && (s_reg.flag || $past(s_reg.flag))))
  else $error("wake without clock hold");

  a_own_code:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && s_reg.if_en && s_reg.st == twr_pkg::S_ADDR_ACK
     && mon.scl_fall && !s_reg.gc && !s_reg.arb)
    |=> (s_reg.code == twr_pkg::CODE_OWN_ADDR) && s_reg.flag)
  else $error("own address code wrong");

  a_arb_gc_code:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && s_reg.if_en && s_reg.st == twr_pkg::S_ADDR_ACK
     && mon.scl_fall && s_reg.gc && s_reg.arb)
    |=> s_reg.code == twr_pkg::CODE_ARB_GC_ADDR)
  else $error("general call after lost arbitration code wrong");

  a_data_ack:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && s_reg.if_en && s_reg.st == twr_pkg::S_DATA_ACK
     && mon.scl_fall && s_reg.ack_given && !s_reg.gc)
    |=> (s_reg.code == twr_pkg::CODE_DATA_ACK)
        && (s_reg.data == $past(s_reg.shift)))
  else $error("acknowledged data not reported");

  a_nack_drop:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && s_reg.st == twr_pkg::S_WAIT && s_reg.drop && !s_reg.flag)
    |=> s_reg.st == twr_pkg::S_IDLE)
  else $error("refused byte did not drop addressing");

  a_nack_drive:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && s_reg.if_en && s_reg.st == twr_pkg::S_DATA
     && byte_end && !mon.start && !mon.stop && !s_reg.ack_en)
    |=> !sda_oe_o ##1 !sda_oe_o)
  else $error("acknowledge driven with enable low");

  a_addr_ignore:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && s_reg.st == twr_pkg::S_ADDR && byte_end && !s_reg.ack_en
     && !mon.start && !mon.stop)
    |=> !sda_oe_o && (s_reg.st == twr_pkg::S_IGNORE
                      || s_reg.st == twr_pkg::S_IDLE))
  else $error("address acknowledged with enable low");

  a_stop_code:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && s_reg.if_en && s_reg.st == twr_pkg::S_DATA && mon.stop)
    |=> s_reg.flag && (s_reg.code == twr_pkg::CODE_STOP_RESTART)
        && (s_reg.st == twr_pkg::S_IDLE))
  else $error("stop while addressed not reported");

  a_start_free:
  assert property (@(posedge clk_i) disable iff (!reset_n_i)
    start_go_o |-> $past(!s_reg.busy && s_reg.sta_req))
  else $error("start raised on a busy bus");

endmodule

`default_nettype wire

// ===== bench/twr_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// master transmitter, one bit is at least 10 clk (1000 ns)
module twr_master_model
(
  // clock
  input  wire logic clk_i,
  // resolved bus lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // open-drain drive, high releases the line
  output var  logic scl_o,
  output var  logic sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // a stretching slave holds the wire, so follow it
  task automatic let_go();
    int n;
    n = 0;
    scl_o <= 1'b1;
    @(posedge clk_i);
    while (!scl_i && n < 5000)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic start();
    repeat (4) @(posedge clk_i);
    sda_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
  endtask
  // data moves a clk after the fall so it never races it
  task automatic put_bit(input logic b, output logic seen);
    @(posedge clk_i);
    sda_o <= b;
    repeat (4) @(posedge clk_i);
    let_go();
    repeat (2) @(posedge clk_i);
    seen = sda_i;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], s);
    put_bit(1'b1, s);
    acked = ~s;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic stop();
    @(posedge clk_i);
    sda_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    let_go();
    repeat (4) @(posedge clk_i);
    sda_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic       clk_i = 1'b0, reset_n_i = 1'b0, wr = 1'b0, rd_s = 1'b0;
  logic       rd_q = 1'b0, sleep = 1'b0, arb_lost = 1'b0;
  logic       scl_oe, sda_oe, wake, start_go, slave_tx, m_scl, m_sda;
  logic       scl_w, sda_w, scl_lv, sda_lv;
  logic [1:0] addr = 2'h0;
  logic [7:0] wr_data = 8'h00, rd_data;
  logic [7:0] exp_q[$];
  int         fail_count = 0, checks_done = 0, cyc = 0;

  // open-drain wires with pull-up; device only ever pulls low
  assign scl_w = m_scl & ~scl_oe;
  assign sda_w = m_sda & ~sda_oe;

  twr_slave_rx #(.REG_AW(2)) i_twr_slave_rx
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .addr_i(addr),
    .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd_s), .rd_data_o(rd_data),
    .scl_i(scl_w), .scl_o(scl_lv), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(sda_lv), .sda_oe_o(sda_oe), .sleep_i(sleep), .arb_lost_i(arb_lost),
    .wake_o(wake), .start_go_o(start_go), .slave_tx_o(slave_tx)
  );
  twr_master_model i_twr_master_model
  (
    .clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl),
    .sda_o(m_sda)
  );

  initial
    forever #50 clk_i = ~clk_i;

  // ==========================================================================
  // checking and verdict
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  // read data stand from the cycle after the strobe until the next read
  always @(posedge clk_i)
  begin
    if (rd_q)
      chk("rd_data", exp_q.pop_front(), rd_data);
    rd_q <= rd_s;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // register port and bus helpers
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_s <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_s <= 1'b0;
  endtask
  task automatic wctl(input logic [7:0] d);
    wr_reg(twr_pkg::REG_CONTROL, d);
  endtask
  // prescaler field stays at 1 from its write after reset onward
  task automatic rsts(input logic [7:0] code);
    rd_reg(twr_pkg::REG_STATUS, code | 8'h01);
  endtask
  task automatic go(input logic first, input logic [7:0] b, input logic e);
    logic a;
    if (first)
      i_twr_master_model.start();
    i_twr_master_model.send_byte(b, a);
    chk("ack", {7'h00, e}, {7'h00, a});
  endtask
  task automatic fin();
    i_twr_master_model.stop();
    repeat (8) @(posedge clk_i);
    wctl(8'hC4);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    logic [6:0] own;
    logic [7:0] d;
    logic       gc, arb;
    void'($urandom(56484));
    own = 7'($urandom_range(126, 2));
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_reg(twr_pkg::REG_OWN_ADDR, 8'hFE);
    rd_reg(twr_pkg::REG_CONTROL, 8'h00);
    rd_reg(twr_pkg::REG_STATUS, 8'hF8);
    wr_reg(twr_pkg::REG_OWN_ADDR, {own, 1'b1});
    wr_reg(twr_pkg::REG_STATUS, 8'h01);
    wctl(8'h44);
    for (int k = 0; k < 4; k++)
    begin
      {arb, gc} = 2'(k);
      // lost arbitration is a one-cycle report before the address
      arb_lost <= arb;
      @(posedge clk_i);
      arb_lost <= 1'b0;
      go(1'b1, gc ? 8'h00 : {own, 1'b0}, 1'b1);
      rsts(8'h60 | {3'h0, gc, arb, 3'h0});
      chk("scl_oe", 8'h01, {7'h00, scl_oe});
      chk("line_lv", 8'h00, {6'h00, scl_lv, sda_lv});
      rd_reg(twr_pkg::REG_CONTROL, 8'hC4);
      wctl(8'hC4);
      d = 8'($urandom);
      go(1'b0, d, 1'b1);
      rsts(8'h80 | {3'h0, gc, 4'h0});
      rd_reg(twr_pkg::REG_DATA, d);
      wctl(8'h84);
      go(1'b0, ~d, 1'b0);
      rsts(8'h88 | {3'h0, gc, 4'h0});
      wctl(8'hC4);
      fin();
    end
    go(1'b1, {own ^ 7'h01, 1'b0}, 1'b0);
    fin();
    wctl(8'h40);
    go(1'b1, {own, 1'b0}, 1'b0);
    fin();
    wctl(8'h04);
    go(1'b1, {own, 1'b0}, 1'b0);
    fin();
    go(1'b1, {own, 1'b0}, 1'b1);
    wctl(8'hC4);
    i_twr_master_model.stop();
    repeat (8) @(posedge clk_i);
    rsts(8'hA0);
    wctl(8'hC4);
    go(1'b1, {own, 1'b1}, 1'b1);
    chk("slave_tx", 8'h01, {7'h00, slave_tx});
    fin();
    sleep <= 1'b1;
    go(1'b1, {own, 1'b0}, 1'b1);
    chk("wake", 8'h01, {7'h00, wake});
    wctl(8'hC4);
    repeat (3) @(posedge clk_i);
    chk("wake", 8'h00, {7'h00, wake});
    chk("scl_oe", 8'h00, {7'h00, scl_oe});
    sleep <= 1'b0;
    fin();
    wctl(8'h64);
    repeat (4) @(posedge clk_i);
    chk("start_go", 8'h01, {7'h00, start_go});
    wctl(8'h44);
    wr_reg(twr_pkg::REG_OWN_ADDR, {own, 1'b0});
    go(1'b1, 8'h00, 1'b0);
    fin();
    finish_test();
  end
endmodule

`default_nettype wire
